// [hw/fcs_pkg.sv]
// Purpose: shared constants and types of the flash configuration and status registers
// Assumes: one clock, sys_clk at 20 MHz; synchronous active-high reset srst
// Notes: offsets are byte addresses on the Avalon-MM slave
package fcs_pkg;

    // ------------------------------------------------------------
    // bus geometry and register offsets
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;                         // byte address width
    localparam logic [15:0] FSG_OFS = 16'h104C;         // flash_size_and_gating
    localparam logic [15:0] FLI_OFS = 16'h1050;         // flash_limit_info
    localparam logic [15:0] IST_OFS = 16'h1080;         // interrupt status, write one to clear
    localparam logic [15:0] IMK_OFS = 16'h1084;         // interrupt mask

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SIZE_LSB = 24;                       // program_flash_size_code low bit
    localparam int SIZE_W = 4;                          // program_flash_size_code width
    localparam int DOZE_BIT = 1;                        // doze_flash_gate
    localparam int OFF_BIT = 0;                         // flash_off
    localparam int LIMIT_LSB = 24;                      // first_invalid_block low bit
    localparam int LIMIT_W = 7;                         // first_invalid_block width
    localparam int ONE_BIT = 23;                        // reserved bit that reads one
    localparam int BLOCK_SHIFT = 13;                    // one block unit is 8 KB

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [1:0] GATE_RST = 2'h0;             // flash enabled, no doze gating
    localparam logic [1:0] EV_RST = 2'h0;               // no events pending
    localparam logic [1:0] MASK_RST = 2'h0;             // all events masked

    // ------------------------------------------------------------
    // program flash size codes
    // ------------------------------------------------------------
    localparam logic [3:0] PFS_8K = 4'h0;               // 0.25 KB regions
    localparam logic [3:0] PFS_16K = 4'h1;              // 0.5 KB regions
    localparam logic [3:0] PFS_32K = 4'h3;              // 1 KB regions
    localparam logic [3:0] PFS_64K = 4'h5;              // 2 KB regions
    localparam logic [3:0] PFS_128K = 4'h7;             // 4 KB regions
    localparam logic [3:0] PFS_256K = 4'h9;             // 8 KB regions
    localparam logic [3:0] PFS_32K_ALT = 4'hF;          // also 32 KB, 1 KB regions
    localparam logic [6:0] LIMIT_32K = 7'h04;           // 32 KB / 8 KB per unit

    // ------------------------------------------------------------
    // event bits of the interrupt status and mask registers
    // ------------------------------------------------------------
    localparam int EV_ERR = 0;                          // flash access refused
    localparam int EV_WAKE = 1;                         // flash back after wake or enable
    localparam int EV_W = 2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 50;                         // sys_clk period
    localparam int WAKE_EXT_NS = 1000;                  // flash power-up time
    localparam int WAKE_EXT_CYC = (WAKE_EXT_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 8;                           // wake counter width

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } fcs_avs_req_t;

    typedef struct packed {
        logic waitrequest;
        logic [31:0] readdata;
    } fcs_avs_rsp_t;

    typedef struct packed {
        logic grant;                                    // access served by flash
        logic err;                                      // access ended in bus error
    } fcs_flash_rsp_t;

    typedef enum logic [1:0] {FG_ON, FG_DOZE, FG_WAKE, FG_OFF} fcs_gate_st_t;

endpackage

// [hw/fcs_flash_gate.sv]
// Purpose: flash power gating sequencer for doze and for disable while flash_off is set
// Assumes: doze_active and control bits come from logic on sys_clk
// Notes: all outputs come from the state register
module fcs_flash_gate (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic doze_active,
    input wire logic doze_gate,
    input wire logic flash_off,
    output logic flash_ready,
    output logic flash_lp,
    output logic wake_hold,
    output logic wake_done
);
    import fcs_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        fcs_gate_st_t st;               // gating state
        logic [CNT_W-1:0] cnt;          // power-up cycles left
        logic ready;                    // flash usable
        logic lp;                       // flash in low power
        logic hold;                     // doze exit still stretched
        logic done;                     // one-cycle flash-back pulse
    } fcs_gate_t;

    fcs_gate_t gate_reg;
    fcs_gate_t gate_next;

    // next state and registered outputs
    always_comb begin
        gate_next = gate_reg;
        gate_next.done = 1'b0;
        unique case (gate_reg.st)
            FG_ON: begin
                if (flash_off) begin
                    gate_next.st = FG_OFF;
                end else if (doze_active && doze_gate) begin
                    gate_next.st = FG_DOZE;
                end
            end
            FG_DOZE: begin
                if (flash_off) begin
                    gate_next.st = FG_OFF;
                end else if (!doze_active) begin
                    // power back without software help
                    gate_next.st = FG_WAKE;
                    gate_next.cnt = CNT_W'(WAKE_EXT_CYC - 1);
                end
            end
            FG_WAKE: begin
                if (flash_off) begin
                    gate_next.st = FG_OFF;
                end else if (doze_active && doze_gate) begin
                    gate_next.st = FG_DOZE;
                end else if (gate_reg.cnt == '0) begin
                    gate_next.st = FG_ON;
                    gate_next.done = 1'b1;
                end else begin
                    gate_next.cnt = gate_reg.cnt - 1'b1;
                end
            end
            FG_OFF: begin
                if (!flash_off) begin
                    // re-enable also needs the power-up time
                    gate_next.st = FG_WAKE;
                    gate_next.cnt = CNT_W'(WAKE_EXT_CYC - 1);
                end
            end
        endcase
        gate_next.ready = (gate_next.st == FG_ON);
        gate_next.lp = (gate_next.st == FG_OFF) || (gate_next.st == FG_DOZE);
        gate_next.hold = (gate_next.st == FG_WAKE) || (gate_next.st == FG_DOZE);
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            gate_reg <= '{st: FG_ON, cnt: '0, ready: 1'b1, lp: 1'b0, hold: 1'b0, done: 1'b0};
        end else begin
            gate_reg <= gate_next;
        end
    end

    assign flash_ready = gate_reg.ready;
    assign flash_lp = gate_reg.lp;
    assign wake_hold = gate_reg.hold;
    assign wake_done = gate_reg.done;

endmodule

// [hw/fcs_regs.sv]
// Purpose: flash configuration and status registers with flash access gating
// Assumes: Avalon-MM master and flash masters on sys_clk; doze_active on sys_clk
// Notes: one answer per request, waitrequest low for exactly one cycle
//
// The Avalon-MM register port is this design's own decision.
module fcs_regs #(
    parameter logic [3:0] SIZE_CODE = fcs_pkg::PFS_32K,
    parameter logic [6:0] LIMIT_CODE = fcs_pkg::LIMIT_32K
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire fcs_pkg::fcs_avs_req_t avs_req,
    output fcs_pkg::fcs_avs_rsp_t avs_rsp,
    input wire logic doze_active,
    input wire logic fl_req,
    output fcs_pkg::fcs_flash_rsp_t fl_rsp,
    output logic flash_ready,
    output logic flash_low_power,
    output logic wake_hold,
    output logic irq
);
    import fcs_pkg::*;

    // ------------------------------------------------------------
    // address decode helpers
    // ------------------------------------------------------------

    // word match, low two address bits ignored
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] ofs);
        hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
    endfunction

    // read value of the word at an address
    function automatic logic [31:0] rd_word(
        input logic [ADDR_W-1:0] a,
        input logic [1:0] gate,
        input logic [EV_W-1:0] st,
        input logic [EV_W-1:0] mk
    );
        // every bit not set below reads as zero
        rd_word = 32'h0000_0000;
        if (hit(a, FSG_OFS)) begin
            // fixed size code
            rd_word[SIZE_LSB +: SIZE_W] = SIZE_CODE;
            rd_word[DOZE_BIT] = gate[DOZE_BIT];
            rd_word[OFF_BIT] = gate[OFF_BIT];
        end else if (hit(a, FLI_OFS)) begin
            // block count, each unit is one 8 KB step
            rd_word[LIMIT_LSB +: LIMIT_W] = LIMIT_CODE;
            rd_word[ONE_BIT] = 1'b1;
        end else if (hit(a, IST_OFS)) begin
            rd_word[EV_W-1:0] = st;
        end else if (hit(a, IMK_OFS)) begin
            rd_word[EV_W-1:0] = mk;
        end
    endfunction

    // ------------------------------------------------------------
    // state of the block
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] gate;                // doze_flash_gate and flash_off
        logic [EV_W-1:0] ev;             // sticky event bits
        logic [EV_W-1:0] mask;           // event enables
        logic wait_q;                    // registered waitrequest
        logic [31:0] rdata;              // registered readdata
        logic grant;                     // flash access served
        logic err;                       // flash access refused
        logic irq;                       // interrupt level
    } fcs_state_t;

    fcs_state_t state_reg;
    fcs_state_t state_next;

    // ------------------------------------------------------------
    // gating sequencer
    // ------------------------------------------------------------
    logic gate_ready;                    // flash usable this cycle
    logic gate_lp;                       // flash powered down
    logic gate_hold;                     // doze exit stretched
    logic gate_done;                     // flash came back

    fcs_flash_gate u_gate (
        .sys_clk(sys_clk),
        .srst(srst),
        .doze_active(doze_active),
        .doze_gate(state_reg.gate[DOZE_BIT]),
        .flash_off(state_reg.gate[OFF_BIT]),
        .flash_ready(gate_ready),
        .flash_lp(gate_lp),
        .wake_hold(gate_hold),
        .wake_done(gate_done)
    );

    // ------------------------------------------------------------
    // combinational helpers
    // ------------------------------------------------------------
    logic req;                           // a bus request is present
    logic done;                          // request completes at this edge
    logic wr_en;                         // write takes effect at this edge
    logic lane0;                         // low byte lane enabled
    logic [EV_W-1:0] ev_set;             // events raised this cycle
    logic [EV_W-1:0] ev_clr;             // write-one-to-clear strobes

    // request and completion
    always_comb begin
        req = avs_req.read || avs_req.write;
        // completion edge: master still holds and sees waitrequest low
        done = req && !state_reg.wait_q;
        wr_en = done && avs_req.write;
        lane0 = avs_req.byteenable[0];
    end

    // event sources
    always_comb begin
        ev_set = '0;
        // refused flash access
        ev_set[EV_ERR] = fl_req && !gate_ready;
        // flash powered again after wake or enable
        ev_set[EV_WAKE] = gate_done;
        ev_clr = '0;
        if (wr_en && lane0 && hit(avs_req.address, IST_OFS)) begin
            ev_clr = avs_req.writedata[EV_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;

        // bus handshake: one answer cycle per request
        if (done) begin
            // transfer finishes now; raise waitrequest for the next one
            state_next.wait_q = 1'b1;
            state_next.rdata = 32'h0000_0000;
        end else if (req) begin
            // request seen: answer in the next cycle
            state_next.wait_q = 1'b0;
            state_next.rdata = rd_word(avs_req.address, state_reg.gate,
                                       state_reg.ev, state_reg.mask);
        end else begin
            // idle
            state_next.wait_q = 1'b1;
            state_next.rdata = 32'h0000_0000;
        end

        // control bits live in the low byte; upper bytes hold only
        // the size code and reserved bits, so their writes are dropped
        if (wr_en && lane0 && hit(avs_req.address, FSG_OFS)) begin
            state_next.gate[DOZE_BIT] = avs_req.writedata[DOZE_BIT];
            state_next.gate[OFF_BIT] = avs_req.writedata[OFF_BIT];
        end

        // the limit register is read only: no write path

        // mask register
        if (wr_en && lane0 && hit(avs_req.address, IMK_OFS)) begin
            state_next.mask = avs_req.writedata[EV_W-1:0];
        end

        // sticky events: a new event wins over a clear in the same cycle
        state_next.ev = (state_reg.ev & ~ev_clr) | ev_set;

        // flash access answer one cycle after the request
        state_next.grant = fl_req && gate_ready;
        state_next.err = fl_req && !gate_ready;

        // level interrupt from unmasked status
        state_next.irq = |(state_next.ev & state_next.mask);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_reg.gate <= GATE_RST;
            state_reg.ev <= EV_RST;
            state_reg.mask <= MASK_RST;
            state_reg.wait_q <= 1'b1;
            state_reg.rdata <= 32'h0000_0000;
            state_reg.grant <= 1'b0;
            state_reg.err <= 1'b0;
            state_reg.irq <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs, each straight from a flip-flop
    // ------------------------------------------------------------
    assign avs_rsp.waitrequest = state_reg.wait_q;
    assign avs_rsp.readdata = state_reg.rdata;
    assign fl_rsp.grant = state_reg.grant;
    assign fl_rsp.err = state_reg.err;
    assign flash_ready = gate_ready;
    assign flash_low_power = gate_lp;
    assign wake_hold = gate_hold;
    assign irq = state_reg.irq;

endmodule

// [bench/fcs_regs_checker.sv]
// Purpose: port-level assertions for the flash configuration and status registers
// Assumes: one clock domain, sys_clk, with synchronous active-high srst
// Notes: gate bits are shadowed from completed bus writes, since the checker sees ports only
module fcs_regs_checker #(
    parameter logic [3:0] SIZE_CODE = fcs_pkg::PFS_32K,
    parameter logic [6:0] LIMIT_CODE = fcs_pkg::LIMIT_32K
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire fcs_pkg::fcs_avs_req_t avs_req,
    input wire fcs_pkg::fcs_avs_rsp_t avs_rsp,
    input wire logic doze_active,
    input wire logic fl_req,
    input wire fcs_pkg::fcs_flash_rsp_t fl_rsp,
    input wire logic flash_ready,
    input wire logic flash_low_power,
    input wire logic wake_hold,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    import fcs_pkg::*;

    // ------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------
    logic [1:0] gate_reg; // shadow of doze gate and flash off
    logic [1:0] gate_next;
    logic fsg_done; // transfer to the gating register completes
    logic fli_done; // transfer to the limit register completes

    assign fsg_done = !avs_rsp.waitrequest && avs_req.address[15:2] == FSG_OFS[15:2];
    assign fli_done = !avs_rsp.waitrequest && avs_req.address[15:2] == FLI_OFS[15:2];

    // follow writes that reach lane 0 of the gating register
    always_comb begin
        gate_next = gate_reg;
        if (fsg_done && avs_req.write && avs_req.byteenable[0]) begin
            gate_next = avs_req.writedata[1:0];
        end
    end

    // shadow register, cleared like the design's control bits
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            gate_reg <= 2'h0;
        end else begin
            gate_reg <= gate_next;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_size_read: assert property (avs_req.read && fsg_done |->
        avs_rsp.readdata[31:2] == {4'h0, SIZE_CODE, 22'h0})
        else $error("size register read wrong");
    a_limit_read: assert property (avs_req.read && fli_done |->
        avs_rsp.readdata == {1'b0, LIMIT_CODE, 1'b1, 23'h0})
        else $error("limit register read wrong");
    a_refused_err: assert property (fl_req && !flash_ready |=>
        fl_rsp.err && !fl_rsp.grant)
        else $error("access to gated flash not refused");
    a_served_grant: assert property (fl_req && flash_ready |=>
        fl_rsp.grant && !fl_rsp.err)
        else $error("access to ready flash not served");
    a_flash_off_blocks: assert property (gate_reg[0] && $past(gate_reg[0], 2) |->
        !flash_ready && flash_low_power)
        else $error("disabled flash still usable");
    a_doze_gates: assert property (doze_active && gate_reg[1] |->
        ##[1:2] (!flash_ready && flash_low_power && wake_hold))
        else $error("gated doze left flash on");
    a_doze_no_gate: assert property (doze_active && gate_reg == 2'h0 && flash_ready |=>
        flash_ready)
        else $error("ungated doze turned flash off");
    a_wake_restore: assert property ($fell(doze_active) && gate_reg == 2'h2 |->
        ##[1:24] flash_ready)
        else $error("flash not back after doze");
    a_wake_stretch: assert property ($fell(doze_active) && gate_reg == 2'h2 && wake_hold |=>
        (wake_hold && !flash_ready) [*8])
        else $error("doze wake not stretched");
    a_bus_answer: assert property ((avs_req.read || avs_req.write) && avs_rsp.waitrequest |->
        ##[1:2] !avs_rsp.waitrequest)
        else $error("bus request not answered");

    // ------------------------------------------------------------
    // covers
    // ------------------------------------------------------------
    c_err: cover property (fl_req ##1 fl_rsp.err);
    c_wake: cover property ($fell(doze_active) ##[1:30] $rose(flash_ready));
    c_irq: cover property ($rose(irq));
    c_limit: cover property (avs_req.read && fli_done);
endmodule

bind fcs_regs fcs_regs_checker #(.SIZE_CODE(SIZE_CODE), .LIMIT_CODE(LIMIT_CODE)) u_chk (
    .sys_clk(sys_clk),
    .srst(srst),
    .avs_req(avs_req),
    .avs_rsp(avs_rsp),
    .doze_active(doze_active),
    .fl_req(fl_req),
    .fl_rsp(fl_rsp),
    .flash_ready(flash_ready),
    .flash_low_power(flash_low_power),
    .wake_hold(wake_hold),
    .irq(irq)
);

// [bench/flash_config_status_regs_tb.sv]
// Purpose: self-checking bench for the flash configuration and status registers
// Assumes: Avalon-MM request held until waitrequest low is sampled
// Notes: built for a 128 KB variant so the size and limit parameters are exercised
module flash_config_status_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import fcs_pkg::*;

    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic [3:0] be;
        logic [31:0] wd;
        logic [31:0] exp;
    } fcs_row_t;

    localparam logic [3:0] SZ = PFS_128K; // size code of this variant
    localparam logic [6:0] LM = 7'h10; // 128 KB at 8 KB a unit
    localparam logic [31:0] FSG_V = {4'h0, SZ, 24'h0};
    localparam logic [31:0] FLI_V = {1'b0, LM, 1'b1, 23'h0};

    logic sys_clk;
    logic srst;
    logic doze_active;
    logic fl_req;
    fcs_avs_req_t avs_req;
    fcs_avs_rsp_t avs_rsp;
    fcs_flash_rsp_t fl_rsp;
    logic flash_ready;
    logic flash_low_power;
    logic wake_hold;
    logic irq;
    logic [4:0] outs; // waitrequest, irq, wake_hold, low power, ready
    int fail_count = 0;
    int checks_done = 0;
    // ordinary register accesses: optional write, then read back
    fcs_row_t rows [0:9] = '{
        '{1'b0, IST_OFS, 4'hF, 32'h0, 32'h0},
        '{1'b0, IMK_OFS, 4'hF, 32'h0, 32'h0},
        '{1'b0, FSG_OFS, 4'hF, 32'h0, FSG_V},
        '{1'b1, FSG_OFS, 4'hF, 32'hFFFFFFFC, FSG_V},
        '{1'b1, FLI_OFS, 4'hF, 32'hFFFFFFFF, FLI_V},
        '{1'b1, FLI_OFS, 4'hF, 32'h0, FLI_V},
        '{1'b1, 16'h1054, 4'hF, 32'hFFFFFFFF, 32'h0},
        '{1'b1, IMK_OFS, 4'hF, 32'h3, 32'h3},
        '{1'b1, IMK_OFS, 4'hF, 32'h0, 32'h0},
        '{1'b1, FSG_OFS, 4'hE, 32'h3, FSG_V}
    };

    assign outs = {avs_rsp.waitrequest, irq, wake_hold, flash_low_power, flash_ready};

    fcs_regs #(.SIZE_CODE(SZ), .LIMIT_CODE(LM)) DUT (
        .sys_clk(sys_clk),
        .srst(srst),
        .avs_req(avs_req),
        .avs_rsp(avs_rsp),
        .doze_active(doze_active),
        .fl_req(fl_req),
        .fl_rsp(fl_rsp),
        .flash_ready(flash_ready),
        .flash_low_power(flash_low_power),
        .wake_hold(wake_hold),
        .irq(irq)
    );

    // clock, 50 ns period
    always #25 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask

    // one transfer; held until waitrequest is sampled low at a rising edge,
    // read data taken and request released at that same edge
    task automatic bus(input logic wr, input logic [15:0] a, input logic [3:0] be,
                       input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_req <= '{read: !wr, write: wr, address: a, byteenable: be, writedata: wd};
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_rsp.waitrequest !== 1'b0 && n < 50);
        chk("bus_answer", 32'h0, {31'h0, avs_rsp.waitrequest});
        rd = avs_rsp.readdata;
        avs_req <= '0;
    endtask

    task automatic wreg(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, 4'hF, d, x);
    endtask

    task automatic rreg(input string nm, input logic [15:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 4'hF, 32'h0, x);
        chk(nm, e, x);
    endtask

    // one flash access cycle; e is {grant, err}
    task automatic flacc(input logic [1:0] e);
        @(posedge sys_clk);
        fl_req <= 1'b1;
        @(posedge sys_clk);
        fl_req <= 1'b0;
        @(negedge sys_clk);
        chk("fl_rsp", {30'h0, e}, {30'h0, fl_rsp});
    endtask

    // wait for the flash to come back, bounded
    task automatic wait_ready();
        int n;
        n = 0;
        @(negedge sys_clk);
        while (flash_ready !== 1'b1 && n < 40) begin
            n++;
            @(negedge sys_clk);
        end
        chk("ready_back", 32'h1, {31'h0, flash_ready});
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] rd;
        sys_clk = 1'b0;
        srst = 1'b1;
        avs_req = '0;
        doze_active = 1'b0;
        fl_req = 1'b0;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        @(negedge sys_clk);
        chk("outs_rst", 32'h11, {27'h0, outs});
        // table of register accesses
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                bus(1'b1, rows[i].addr, rows[i].be, rows[i].wd, rd);
            end
            rreg("row_read", rows[i].addr, rows[i].exp);
        end
        // flash enabled: served; then disabled, refused with an unmasked event
        flacc(2'b10);
        wreg(IMK_OFS, 32'h1);
        wreg(FSG_OFS, 32'h1);
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("gate_off", 32'h2, {30'h0, flash_low_power, flash_ready});
        flacc(2'b01);
        chk("irq_err", 32'h1, {31'h0, irq});
        rreg("ist_err", IST_OFS, 32'h1);
        wreg(IST_OFS, 32'h1);
        rreg("ist_clr", IST_OFS, 32'h0);
        chk("irq_clr", 32'h0, {31'h0, irq});
        // masked event stays quiet until unmasked
        wreg(IMK_OFS, 32'h0);
        flacc(2'b01);
        chk("irq_mask", 32'h0, {31'h0, irq});
        wreg(IMK_OFS, 32'h1);
        @(negedge sys_clk);
        chk("irq_unmask", 32'h1, {31'h0, irq});
        wreg(IST_OFS, 32'h1);
        wreg(IMK_OFS, 32'h3);
        // enable again: flash returns after power-up
        wreg(FSG_OFS, 32'h0);
        wait_ready();
        rreg("ist_back", IST_OFS, 32'h2);
        wreg(IST_OFS, 32'h3);
        // gated doze: off during doze, back by itself after
        wreg(FSG_OFS, 32'h2);
        @(posedge sys_clk);
        doze_active <= 1'b1;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("outs_doze", 32'h16, {27'h0, outs});
        flacc(2'b01);
        wreg(IST_OFS, 32'h3);
        @(posedge sys_clk);
        doze_active <= 1'b0;
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("wake_stretch", 32'h2, {30'h0, wake_hold, flash_ready});
        wait_ready();
        flacc(2'b10);
        wreg(IST_OFS, 32'h3);
        // ungated doze keeps the flash usable
        wreg(FSG_OFS, 32'h0);
        @(posedge sys_clk);
        doze_active <= 1'b1;
        repeat (5) @(posedge sys_clk);
        flacc(2'b10);
        @(posedge sys_clk);
        doze_active <= 1'b0;
        // reset in mid-run restores the control bits
        wreg(FSG_OFS, 32'h3);
        @(posedge sys_clk);
        srst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        @(negedge sys_clk);
        chk("outs_rst2", 32'h11, {27'h0, outs});
        rreg("fsg_rst2", FSG_OFS, FSG_V);
        summarize();
    end

    // watchdog, well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (5000) @(posedge sys_clk);
        fail_count++;
        summarize();
    end
endmodule
